// ---- cec_pkg.sv ----
package cec_pkg;
	localparam logic [7:0] ADDR_MIS   = 8'h00;
	localparam logic [7:0] ADDR_RIS   = 8'h04;
	localparam logic [7:0] ADDR_INTEN = 8'h08;
	localparam logic [7:0] ADDR_STAT  = 8'h20;
	localparam logic [7:0] ADDR_CTL   = 8'h24;

	localparam int BIT_TX_EN     = 11;
	localparam int BIT_SRC_HI    = 10;
	localparam int BIT_SRC_LO    = 9;
	localparam int BIT_ADC_LVL   = 7;
	localparam int BIT_ADC_SEN_HI = 6;
	localparam int BIT_ADC_SEN_LO = 5;
	localparam int BIT_IRQ_LVL   = 4;
	localparam int BIT_IRQ_SEN_HI = 3;
	localparam int BIT_IRQ_SEN_LO = 2;
	localparam int BIT_INVERT    = 1;
	localparam int BIT_OUT_VALUE = 1;
	localparam int BIT_FLAG      = 0;

	localparam logic [31:0] CTL_WR_MASK = 32'h00000EFE;
	localparam logic [31:0] CTL_RESET   = 32'h00000000;

	typedef enum logic [1:0] {
		SRC_PIN_VALUE = 2'h0,
		SRC_POS_PIN   = 2'h1,
		SRC_VREF      = 2'h2,
		SRC_RESERVED  = 2'h3
	} cec_src_t;

	typedef enum logic [1:0] {
		SENSE_LEVEL   = 2'h0,
		SENSE_FALLING = 2'h1,
		SENSE_RISING  = 2'h2,
		SENSE_EITHER  = 2'h3
	} cec_sense_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} cec_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} cec_apb_rsp_t;
endpackage

// ---- cec_sense.sv ----
`timescale 1ns/1ns
// One sense conditioner: level or edge qualification of the conditioned output
module cec_sense (
	input  wire logic             i_clk,
	input  wire logic             i_nrst,
	input  wire logic             i_val,
	input  wire logic             i_prev,
	input  wire cec_pkg::cec_sense_t i_mode,
	input  wire logic             i_level,
	output logic                  o_event
);
	import cec_pkg::*;

	logic rise;
	logic fall;
	logic next_event;

	assign rise = i_val & ~i_prev;
	assign fall = ~i_val & i_prev;

	always_comb begin
		unique case (i_mode)
			SENSE_LEVEL:   next_event = (i_val == i_level);
			SENSE_FALLING: next_event = fall;
			SENSE_RISING:  next_event = rise;
			SENSE_EITHER:  next_event = rise | fall;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_event <= 1'b0;
		end else begin
			o_event <= next_event;
		end
	end
endmodule // cec_sense

// ---- cec_top.sv ----
// Chosen here: the APB slave port.
`timescale 1ns/1ns
// Operation
// - Transmit enable gates ADC trigger forwarding.
// - Source select routes plus input; 11 reserved.
// - ADC sense: level, falling, rising, either.
// - ADC level mode fires on matching level.
// - Interrupt sense: level, falling, rising, either.
// - Interrupt level mode fires on matching level.
// - Invert bit flips output before processing.
// - Reserved bits ignored; fields reset zero.
// - Raw status sets regardless of enable.
// - Masked status is raw AND enable; W1C.
// - Enable gates interrupt line.
// - Status register shows current output.
module cec_top (
	input  wire logic                 I_REF_CLK,
	input  wire logic                 I_NRST,
	input  wire cec_pkg::cec_apb_req_t I_APB,
	input  wire logic                 I_CMP_OUT,
	output cec_pkg::cec_apb_rsp_t     O_APB,
	output cec_pkg::cec_src_t         O_POS_SRC_SEL,
	output logic                      O_ADC_TRIGGER,
	output logic                      O_IRQ
);
	import cec_pkg::*;

	logic [31:0] comparator_control;
	logic        irq_enable;
	logic        cmp_zero_interrupt_flag;
	logic        sync_meta;
	logic        sync_out;
	logic        cond_prev;
	logic        comparator_output_value;

	wire         setup_phase;
	wire         wr_en;
	wire         sel_mis;
	wire         sel_ris;
	wire         sel_inten;
	wire         sel_stat;
	wire         sel_ctl;
	wire         mapped;
	wire         cond_val;
	wire         irq_event;
	wire         adc_event;
	wire         flag_clear;
	wire         next_flag;
	wire [31:0]  next_rdata;
	wire         adc_tx_en;
	wire         adc_lvl;
	wire         irq_lvl;
	wire         out_invert;
	wire         masked_status;
	cec_sense_t  adc_sense_select;
	cec_sense_t  irq_sense_select;

	// Zero-wait slave: answer on the first access cycle
	assign setup_phase = I_APB.psel & ~I_APB.penable;
	assign wr_en       = I_APB.psel & I_APB.penable & I_APB.pwrite;
	assign sel_mis     = (I_APB.paddr == ADDR_MIS);
	assign sel_ris     = (I_APB.paddr == ADDR_RIS);
	assign sel_inten   = (I_APB.paddr == ADDR_INTEN);
	assign sel_stat    = (I_APB.paddr == ADDR_STAT);
	assign sel_ctl     = (I_APB.paddr == ADDR_CTL);
	assign mapped      = sel_mis | sel_ris | sel_inten | sel_stat | sel_ctl;

	assign adc_tx_en        = comparator_control[BIT_TX_EN];
	assign adc_lvl          = comparator_control[BIT_ADC_LVL];
	assign irq_lvl          = comparator_control[BIT_IRQ_LVL];
	assign out_invert       = comparator_control[BIT_INVERT];
	assign adc_sense_select = cec_sense_t'(comparator_control[BIT_ADC_SEN_HI:BIT_ADC_SEN_LO]);
	assign irq_sense_select = cec_sense_t'(comparator_control[BIT_IRQ_SEN_HI:BIT_IRQ_SEN_LO]);

	// Invert before any sensing so both paths see the same polarity
	assign cond_val = sync_out ^ out_invert;

	// two-flop synchroniser; only sync_out is looked at downstream
	always_ff @(posedge I_REF_CLK) begin
		if (!I_NRST) begin
			sync_meta <= 1'b0;
			sync_out  <= 1'b0;
			cond_prev <= 1'b0;
		end else begin
			sync_meta <= I_CMP_OUT;
			sync_out  <= sync_meta;
			cond_prev <= cond_val;
		end
	end

	cec_sense u_irq_sense (
		.i_clk   (I_REF_CLK),
		.i_nrst  (I_NRST),
		.i_val   (cond_val),
		.i_prev  (cond_prev),
		.i_mode  (irq_sense_select),
		.i_level (irq_lvl),
		.o_event (irq_event)
	);

	cec_sense u_adc_sense (
		.i_clk   (I_REF_CLK),
		.i_nrst  (I_NRST),
		.i_val   (cond_val),
		.i_prev  (cond_prev),
		.i_mode  (adc_sense_select),
		.i_level (adc_lvl),
		.o_event (adc_event)
	);

	// A new event wins over a same-cycle write-one clear
	assign flag_clear = wr_en & sel_mis & I_APB.pwdata[BIT_FLAG];
	assign next_flag  = irq_event | (cmp_zero_interrupt_flag & ~flag_clear);
	assign masked_status = cmp_zero_interrupt_flag & irq_enable;

	assign next_rdata =
		sel_mis   ? {31'h00000000, masked_status} :
		sel_ris   ? {31'h00000000, cmp_zero_interrupt_flag} :
		sel_inten ? {31'h00000000, irq_enable} :
		sel_stat  ? (32'(comparator_output_value) << BIT_OUT_VALUE) :
		sel_ctl   ? comparator_control :
		32'h00000000;

	always_ff @(posedge I_REF_CLK) begin
		if (!I_NRST) begin
			comparator_control      <= CTL_RESET;
			irq_enable              <= 1'b0;
			cmp_zero_interrupt_flag <= 1'b0;
		end else begin
			cmp_zero_interrupt_flag <= next_flag;
			if (wr_en && sel_ctl) begin
				comparator_control <= I_APB.pwdata & CTL_WR_MASK;
			end
			if (wr_en && sel_inten) begin
				irq_enable <= I_APB.pwdata[BIT_FLAG];
			end
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (!I_NRST) begin
			comparator_output_value <= 1'b0;
			O_ADC_TRIGGER           <= 1'b0;
			O_IRQ                   <= 1'b0;
			O_POS_SRC_SEL           <= SRC_PIN_VALUE;
		end else begin
			comparator_output_value <= cond_val;
			O_ADC_TRIGGER           <= adc_event & adc_tx_en;
			O_IRQ                   <= next_flag & irq_enable;
			O_POS_SRC_SEL           <= cec_src_t'(comparator_control[BIT_SRC_HI:BIT_SRC_LO]);
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (!I_NRST) begin
			O_APB <= '0;
		end else begin
			O_APB.pready  <= setup_phase;
			O_APB.pslverr <= setup_phase & ~mapped;
			O_APB.prdata  <= next_rdata;
		end
	end

	// Assertions

	a_adc_gate_off: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		!$past(adc_tx_en) |-> !O_ADC_TRIGGER)
		else $error("ADC trigger passed while transmit disabled");

	a_adc_gate_on: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		$past(adc_event) && $past(adc_tx_en) |-> O_ADC_TRIGGER)
		else $error("ADC event not forwarded");

	a_src_route: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		##1 O_POS_SRC_SEL == $past(comparator_control[BIT_SRC_HI:BIT_SRC_LO]))
		else $error("Source select not routed");

	a_adc_rise_sense: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		adc_sense_select == SENSE_RISING && cond_val && !cond_prev |=> adc_event)
		else $error("ADC rising edge missed");

	a_adc_level_sense: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		adc_sense_select == SENSE_LEVEL && cond_val != adc_lvl |=> !adc_event)
		else $error("ADC level event on wrong level");

	a_irq_fall_sense: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		irq_sense_select == SENSE_FALLING && !cond_val && cond_prev |=> irq_event)
		else $error("Interrupt falling edge missed");

	a_irq_level_sense: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		irq_sense_select == SENSE_LEVEL && cond_val == irq_lvl |=> irq_event)
		else $error("Interrupt level event missed");

	a_invert_path: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		##1 comparator_output_value == ($past(sync_out) ^ $past(out_invert)))
		else $error("Invert not applied");

	a_ctl_reserved: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		(comparator_control & ~CTL_WR_MASK) == 32'h00000000)
		else $error("Reserved control bits stored");

	a_raw_set: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		irq_event |=> cmp_zero_interrupt_flag)
		else $error("Raw status not set by event");

	a_w1c_clear: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		flag_clear && !irq_event |=> !cmp_zero_interrupt_flag)
		else $error("Write one did not clear status");

	a_irq_masked: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		##1 O_IRQ == ($past(next_flag) && $past(irq_enable)))
		else $error("Interrupt line not gated by enable");

	a_adc_level_fire: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		adc_sense_select == SENSE_LEVEL && cond_val == adc_lvl
		|=> adc_event)
		else $error("ADC level event missed");

	a_adc_fall_sense: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		adc_sense_select == SENSE_FALLING && !cond_val && cond_prev
		|=> adc_event)
		else $error("ADC falling edge missed");

	a_adc_either_sense: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		adc_sense_select == SENSE_EITHER && cond_val != cond_prev
		|=> adc_event)
		else $error("ADC either edge missed");

	a_adc_edge_quiet: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		adc_sense_select != SENSE_LEVEL && cond_val == cond_prev
		|=> !adc_event)
		else $error("ADC edge event without a change");

	a_adc_rise_only: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		adc_sense_select == SENSE_RISING && !(cond_val && !cond_prev)
		|=> !adc_event)
		else $error("ADC rising mode fired on a fall");

	a_irq_rise_sense: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		irq_sense_select == SENSE_RISING && cond_val && !cond_prev
		|=> irq_event)
		else $error("Interrupt rising edge missed");

	a_irq_either_sense: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		irq_sense_select == SENSE_EITHER && cond_val != cond_prev
		|=> irq_event)
		else $error("Interrupt either edge missed");

	a_irq_edge_quiet: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		irq_sense_select != SENSE_LEVEL && cond_val == cond_prev
		|=> !irq_event)
		else $error("Interrupt edge event without a change");

	a_irq_fall_only: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		irq_sense_select == SENSE_FALLING && !(!cond_val && cond_prev)
		|=> !irq_event)
		else $error("Interrupt falling mode fired on a rise");

	a_irq_level_quiet: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		irq_sense_select == SENSE_LEVEL && cond_val != irq_lvl
		|=> !irq_event)
		else $error("Interrupt level event on wrong level");

	a_sync_first: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		##1
		sync_meta == $past(I_CMP_OUT))
		else $error("First sync stage lost the input");

	a_sync_second: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		##1
		sync_out == $past(sync_meta))
		else $error("Second sync stage lost the input");

	a_prev_track: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		##1
		cond_prev == $past(cond_val))
		else $error("Previous value not registered");

	a_adc_trig_gate: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		O_ADC_TRIGGER
		|-> $past(adc_event) && $past(adc_tx_en))
		else $error("ADC trigger without a gated event");

	a_irq_from_flag: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		O_IRQ
		|-> cmp_zero_interrupt_flag)
		else $error("Interrupt line high without status");

	a_irq_enable_off: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		!$past(irq_enable)
		|-> !O_IRQ)
		else $error("Interrupt line high while disabled");

	a_mis_read: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		setup_phase && sel_mis
		|=> O_APB.prdata == {31'h0, $past(masked_status)})
		else $error("Masked status read wrong");

	a_ris_read: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		setup_phase && sel_ris
		|=> O_APB.prdata == {31'h0, $past(cmp_zero_interrupt_flag)})
		else $error("Raw status read wrong");

	a_stat_read: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		setup_phase && sel_stat
		|=> O_APB.prdata == (32'($past(comparator_output_value)) << BIT_OUT_VALUE))
		else $error("Output status read wrong");

	a_ctl_read: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		setup_phase && sel_ctl
		|=> O_APB.prdata == $past(comparator_control))
		else $error("Control read wrong");

	a_ctl_write_mask: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		wr_en && sel_ctl
		|=> comparator_control == ($past(I_APB.pwdata) & CTL_WR_MASK))
		else $error("Control write not masked");

	a_w1c_keep: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		wr_en && sel_mis && !I_APB.pwdata[BIT_FLAG] && cmp_zero_interrupt_flag
		|=> cmp_zero_interrupt_flag)
		else $error("Write zero cleared status");

	a_flag_hold: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		cmp_zero_interrupt_flag && !flag_clear
		|=> cmp_zero_interrupt_flag)
		else $error("Raw status dropped without a clear");

	a_flag_no_spur: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		!cmp_zero_interrupt_flag && !irq_event
		|=> !cmp_zero_interrupt_flag)
		else $error("Raw status set without an event");

	a_inten_write: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		wr_en && sel_inten
		|=> irq_enable == $past(I_APB.pwdata[BIT_FLAG]))
		else $error("Interrupt enable write lost");

	a_ready_answer: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		setup_phase
		|=> O_APB.pready)
		else $error("No ready after setup");

	a_ready_quiet: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		!setup_phase
		|=> !O_APB.pready)
		else $error("Ready without a setup");

	a_err_unmapped: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		setup_phase && !mapped
		|=> O_APB.pslverr)
		else $error("Unmapped access not refused");

	a_err_mapped: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		setup_phase && mapped
		|=> !O_APB.pslverr)
		else $error("Mapped access refused");
endmodule // cec_top

// ---- cec_cmp_model.sv ----
`timescale 1ns/1ns
// Comparator output and ADC trigger input on the far side of the block
module cec_cmp_model (
	input  wire logic i_clk,
	input  wire logic i_level,
	input  wire logic i_trig,
	output logic      o_cmp,
	output int        o_n_trig
);
	int count = 0;

	// The real output is asynchronous; the bench changes it right after an edge
	assign o_cmp    = i_level;
	assign o_n_trig = count;
	// The ADC takes one trigger per cycle that it sees the line high
	always @(posedge i_clk) begin
		if (i_trig === 1'b1) begin
			count <= count + 1;
		end
	end
endmodule // cec_cmp_model

// ---- cec_top_tb.sv ----
`timescale 1ns/1ns
module cec_top_tb;
	import cec_pkg::*;
	logic         clk = 1'b0;
	logic         nrst = 1'b0;
	logic         level = 1'b0;
	cec_apb_req_t req = '0;
	cec_apb_rsp_t rsp;
	cec_src_t     src;
	logic         trig, irq, cmp, err;
	logic [31:0]  rd;
	int           n_trig, n0;
	int           n_errors = 0;
	int           checked = 0;

	always #4 clk = ~clk;

	cec_top DUT (.I_REF_CLK(clk), .I_NRST(nrst), .I_APB(req), .I_CMP_OUT(cmp),
		.O_APB(rsp), .O_POS_SRC_SEL(src), .O_ADC_TRIGGER(trig), .O_IRQ(irq));
	cec_cmp_model u_cmp (.i_clk(clk), .i_level(level), .i_trig(trig), .o_cmp(cmp),
		.o_n_trig(n_trig));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic test_done;
		$display("checked=%0d n_errors=%0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Holds the request until pready is seen at an edge, then releases it
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		req <= '{psel:1'b1, penable:1'b0, pwrite:wr, paddr:a, pwdata:d};
		@(posedge clk);
		req.penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (rsp.pready === 1'b1) break;
		end
		rd = rsp.prdata;
		err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		if (i == 20) begin
			n_errors++;
			test_done();
		end
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	// Six edges covers the sync, sense and flag stages
	task automatic drive(input logic v);
		@(posedge clk);
		level <= v;
		repeat (6) @(posedge clk);
	endtask

	task automatic t_regs;
		rdchk(ADDR_CTL, 32'h0);
		rdchk(ADDR_RIS, 32'h1);
		apb(1'b1, ADDR_CTL, 32'hFFFFFFFF);
		rdchk(ADDR_CTL, 32'h00000EFE);
		chk(32'(src), 32'h3);
		for (int s = 0; s < 3; s++) begin
			apb(1'b1, ADDR_CTL, 32'(s) << 9);
			repeat (2) @(posedge clk);
			chk(32'(src), 32'(s));
		end
		apb(1'b0, 8'h10, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
	endtask

	task automatic t_edges;
		apb(1'b1, ADDR_INTEN, 32'h1);
		for (int m = 1; m < 4; m++) begin
			apb(1'b1, ADDR_CTL, 32'h800 | (32'(m) << 5) | (32'(m) << 2));
			apb(1'b1, ADDR_MIS, 32'h1);
			n0 = n_trig;
			drive(1'b1);
			chk(32'(n_trig - n0), {31'h0, m[1]});
			chk({31'h0, irq}, {31'h0, m[1]});
			rdchk(ADDR_RIS, {31'h0, m[1]});
			apb(1'b1, ADDR_MIS, 32'h1);
			n0 = n_trig;
			drive(1'b0);
			chk(32'(n_trig - n0), {31'h0, m[0]});
			rdchk(ADDR_RIS, {31'h0, m[0]});
		end
	endtask

	task automatic t_level;
		for (int v = 0; v < 2; v++) begin
			apb(1'b1, ADDR_INTEN, 32'h0);
			apb(1'b1, ADDR_CTL, 32'h800 | (32'(v) << 7) | (32'(v) << 4));
			drive(v[0]);
			chk({31'h0, trig}, 32'h1);
			apb(1'b1, ADDR_MIS, 32'h1);
			rdchk(ADDR_RIS, 32'h1);
			rdchk(ADDR_MIS, 32'h0);
			chk({31'h0, irq}, 32'h0);
			apb(1'b1, ADDR_INTEN, 32'h1);
			rdchk(ADDR_MIS, 32'h1);
			chk({31'h0, irq}, 32'h1);
			drive(~v[0]);
			chk({31'h0, trig}, 32'h0);
			apb(1'b1, ADDR_MIS, 32'h1);
			rdchk(ADDR_RIS, 32'h0);
		end
	endtask

	task automatic t_misc;
		apb(1'b1, ADDR_CTL, 32'h40);
		n0 = n_trig;
		drive(1'b1);
		chk(32'(n_trig - n0), 32'h0);
		rdchk(ADDR_STAT, 32'h2);
		apb(1'b1, ADDR_CTL, 32'hA);
		apb(1'b1, ADDR_MIS, 32'h1);
		rdchk(ADDR_STAT, 32'h0);
		drive(1'b0);
		rdchk(ADDR_RIS, 32'h1);
	endtask

	initial begin
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		t_regs();
		t_edges();
		t_level();
		t_misc();
		test_done();
	end
endmodule // cec_top_tb
